// ---- bench/helm_station_mode_control_chk.sv ----
/*
 port checker for the helm station mode control.
 assumes one clock domain and the async active-low reset of the top module.
*/
`timescale 1ns/1ps
module helm_station_mode_control_chk #(
	parameter integer NUM_STATIONS = 4,
	parameter integer LEV_W        = 8
) (
	// clock and reset
	input wire                    sys_clk_i,
	input wire                    rstn_i,
	// watched inputs
	input wire                    revision_match_i,
	// watched outputs
	input wire [NUM_STATIONS-1:0] transfer_lamp_o,
	input wire [NUM_STATIONS-1:0] lock_lamp_o,
	input wire [NUM_STATIONS-1:0] warmup_lamp_o,
	input wire [NUM_STATIONS-1:0] match_lamp_o,
	input wire [LEV_W-1:0]        main_throttle_o,
	input wire [1:0]              main_clutch_o,
	input wire [1:0]              aux_clutch_o,
	input wire                    brake_neutral_o,
	input wire                    operational_o,
	input wire [NUM_STATIONS-1:0] station_sel_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);

	// lamps and selection are registered on the same edge; compare once the selection has settled
	sequence s_sel_settled;
		(operational_o && $stable(station_sel_o)) [*2];
	endsequence
	sequence s_clutch_engaged;
		(main_clutch_o != 2'h0 || aux_clutch_o != 2'h0) [*2];
	endsequence
	sequence s_clutch_neutral;
		(main_clutch_o == 2'h0 && aux_clutch_o == 2'h0) [*2];
	endsequence

	a_powerup_main_sel: assert property ($rose(rstn_i) |-> ##1 (station_sel_o == 1 && lock_lamp_o == 1))
		else $error("power-up selection or lock wrong");
	a_lamp_tracks_sel: assert property (s_sel_settled |-> transfer_lamp_o == station_sel_o)
		else $error("transfer lamp differs from selection");
	a_one_station: assert property (operational_o |-> $onehot(station_sel_o))
		else $error("selection not one station");
	a_match_at_sel: assert property (match_lamp_o != 0 |-> (match_lamp_o & ~station_sel_o) == 0)
		else $error("match lamp at unselected head");
	a_lock_at_sel: assert property (lock_lamp_o != 0 |-> lock_lamp_o == station_sel_o)
		else $error("lock lamp not at selected head");
	a_idle_no_drive: assert property (!operational_o |-> (main_throttle_o == 0 && main_clutch_o == 2'h0))
		else $error("engine driven before operational");
	a_warm_clutch_neutral: assert property (warmup_lamp_o != 0 |-> (main_clutch_o == 2'h0 && aux_clutch_o == 2'h0))
		else $error("clutch engaged in warm-up");
	a_warm_safety_on: assert property (warmup_lamp_o != 0 |-> brake_neutral_o)
		else $error("neutral safety off in warm-up");
	a_brake_open: assert property (s_clutch_engaged |-> !brake_neutral_o)
		else $error("brake contacts closed with gear in");
	a_brake_closed: assert property (s_clutch_neutral |-> brake_neutral_o)
		else $error("brake contacts open at neutral");
	a_match_revision: assert property ((!revision_match_i) [*3] |-> match_lamp_o == 0)
		else $error("matching active with revision mismatch");
endmodule // helm_station_mode_control_chk

bind helm_station_mode_control helm_station_mode_control_chk #(.NUM_STATIONS(NUM_STATIONS), .LEV_W(LEV_W)) u_chk (
	.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .revision_match_i(revision_match_i),
	.transfer_lamp_o(transfer_lamp_o), .lock_lamp_o(lock_lamp_o), .warmup_lamp_o(warmup_lamp_o),
	.match_lamp_o(match_lamp_o), .main_throttle_o(main_throttle_o), .main_clutch_o(main_clutch_o),
	.aux_clutch_o(aux_clutch_o), .brake_neutral_o(brake_neutral_o), .operational_o(operational_o),
	.station_sel_o(station_sel_o)
);

// ---- bench/shaft_pickup_model.sv ----
/*
 far-side model: main and auxiliary shaft pickups.
 assumes periods are given in system clock cycles by the bench.
*/
`timescale 1ns/1ps
module shaft_pickup_model (
	// clock and reset
	input  wire        sys_clk_i,
	input  wire        rstn_i,
	// shaft speeds as pulse periods
	input  wire [15:0] main_period_i,
	input  wire [15:0] aux_period_i,
	// pickups
	output reg         main_pickup_o,
	output reg         aux_pickup_o
);
	reg [15:0] main_cnt_r;
	reg [15:0] aux_cnt_r;

	// a zero period means the shaft stands still and the line stays low
	always @(negedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			main_cnt_r    <= 16'h0;
			aux_cnt_r     <= 16'h0;
			main_pickup_o <= 1'b0;
			aux_pickup_o  <= 1'b0;
		end else begin
			main_cnt_r    <= (main_cnt_r + 16'h1 >= main_period_i) ? 16'h0 : main_cnt_r + 16'h1;
			aux_cnt_r     <= (aux_cnt_r + 16'h1 >= aux_period_i) ? 16'h0 : aux_cnt_r + 16'h1;
			main_pickup_o <= (main_period_i != 16'h0) && (main_cnt_r < 16'h2);
			aux_pickup_o  <= (aux_period_i != 16'h0) && (aux_cnt_r < 16'h2);
		end
	end
endmodule // shaft_pickup_model

// ---- bench/tb_helm_station_mode_control.sv ----
/*
 testbench: transfer, lock, warm-up and speed matching through the ports.
 assumes shortened debounce (4), flash (8) and window (64) counts.
*/
`timescale 1ns/1ps
module tb_helm_station_mode_control;
	reg         sys_clk_i;
	reg         rstn_i;
	reg  [3:0]  btn [0:3];
	reg  [31:0] port_lev;
	reg  [31:0] stbd_lev;
	reg  [3:0]  port_rev;
	reg  [3:0]  stbd_rev;
	reg         rev_ok;
	integer     main_per, aux_per, n_mismatch, tests_run, i, k;
	wire [3:0]  xfer_lamp, lock_lamp, warm_lamp, match_lamp, sel;
	wire [7:0]  main_thr, aux_thr;
	wire [1:0]  main_clu, aux_clu;
	wire        brake, oper, main_pu, aux_pu;

	helm_station_mode_control #(.DEBOUNCE_CYC(4), .FLASH_CYC(8), .WINDOW_CYC(64)) dut (
		.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .transfer_btn_i(btn[0]), .lock_btn_i(btn[1]),
		.warmup_btn_i(btn[2]), .shaft_match_btn_i(btn[3]), .port_lever_i(port_lev), .stbd_lever_i(stbd_lev),
		.port_dir_rev_i(port_rev), .stbd_dir_rev_i(stbd_rev), .revision_match_i(rev_ok),
		.main_pickup_i(main_pu), .aux_pickup_i(aux_pu), .transfer_lamp_o(xfer_lamp), .lock_lamp_o(lock_lamp),
		.warmup_lamp_o(warm_lamp), .match_lamp_o(match_lamp), .main_throttle_o(main_thr),
		.aux_throttle_o(aux_thr), .main_clutch_o(main_clu), .aux_clutch_o(aux_clu),
		.brake_neutral_o(brake), .operational_o(oper), .station_sel_o(sel));

	shaft_pickup_model pickups (
		.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .main_period_i(main_per[15:0]),
		.aux_period_i(aux_per[15:0]), .main_pickup_o(main_pu), .aux_pickup_o(aux_pu));

	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		begin
			tests_run = tests_run + 1;
			if (got !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("mismatch %0s expected %0h seen %0h", name, exp, got);
			end
		end
	endtask

	// held well past the debounce count so exactly one event is expected
	task press(input integer kind, input integer st);
		begin
			@(negedge sys_clk_i) btn[kind][st] = 1'b1;
			repeat (12) @(negedge sys_clk_i);
			btn[kind][st] = 1'b0;
			repeat (12) @(negedge sys_clk_i);
		end
	endtask

	task lev(input integer st, input [7:0] p, input [7:0] s);
		begin
			@(negedge sys_clk_i);
			port_lev[st*8 +: 8] = p;
			stbd_lev[st*8 +: 8] = s;
			repeat (3) @(negedge sys_clk_i);
		end
	endtask

	task t_power;
		begin
			chk("sel", 4'h1, sel);
			chk("lock_lamp", 4'h1, lock_lamp);
			press(0, 1);
			chk("oper", 1'b0, oper);
			lev(0, 8'h40, 8'h00);
			press(0, 0);
			chk("oper", 1'b0, oper);
			lev(0, 8'h00, 8'h00);
			@(negedge sys_clk_i) btn[0][0] = 1'b1;
			repeat (2) @(negedge sys_clk_i);
			btn[0][0] = 1'b0;
			repeat (10) @(negedge sys_clk_i);
			chk("oper", 1'b0, oper);
			press(0, 0);
			chk("oper", 1'b1, oper);
			chk("xfer_lamp", 4'h1, xfer_lamp);
			$display("test power done");
		end
	endtask

	task t_lock;
		begin
			press(0, 2);
			chk("sel", 4'h1, sel);
			press(1, 0);
			chk("lock_lamp", 4'h0, lock_lamp);
			press(0, 2);
			chk("sel", 4'h4, sel);
			chk("xfer_lamp", 4'h4, xfer_lamp);
			press(1, 0);
			chk("lock_lamp", 4'h0, lock_lamp);
			press(1, 2);
			chk("lock_lamp", 4'h4, lock_lamp);
			lev(0, 8'h50, 8'h50);
			chk("main_thr", 8'h00, main_thr);
			$display("test lock done");
		end
	endtask

	task t_warm;
		begin
			lev(2, 8'h30, 8'h00);
			press(2, 2);
			chk("warm_lamp", 4'h0, warm_lamp);
			lev(2, 8'h00, 8'h00);
			press(2, 2);
			chk("warm_lamp", 4'h4, warm_lamp);
			lev(2, 8'h64, 8'h64);
			chk("main_thr", 8'h64, main_thr);
			chk("main_clu", 2'h0, main_clu);
			chk("brake", 1'b1, brake);
			press(2, 2);
			chk("warm_lamp", 4'h4, warm_lamp);
			lev(2, 8'h00, 8'h00);
			press(2, 2);
			chk("warm_lamp", 4'h0, warm_lamp);
			$display("test warm done");
		end
	endtask

	task t_match;
		begin
			lev(2, 8'h64, 8'h8C);
			press(3, 2);
			chk("match_lamp", 4'h0, match_lamp);
			lev(2, 8'h64, 8'h6E);
			press(3, 2);
			main_per = 10;
			// twice the main period keeps every full window at least two pulses apart, outside the dead band
			aux_per = 20;
			stbd_rev[2] = 1'b1;
			repeat (300) @(negedge sys_clk_i);
			k = 0;
			for (i = 0; i < 20; i = i + 1) begin
				@(negedge sys_clk_i);
				k = k | (match_lamp[2] ? 2 : 1);
			end
			chk("lamp_flash", 3, k);
			chk("aux_up", 1'b1, aux_thr > 8'h64);
			chk("aux_clu", 2'h1, aux_clu);
			chk("brake", 1'b0, brake);
			aux_per = 10;
			repeat (200) @(negedge sys_clk_i);
			k = 0;
			for (i = 0; i < 20; i = i + 1) begin
				@(negedge sys_clk_i);
				k = k | (match_lamp[2] ? 2 : 1);
			end
			chk("lamp_steady", 2, k);
			k = aux_thr;
			aux_per = 6;
			repeat (200) @(negedge sys_clk_i);
			chk("aux_down", 1'b1, aux_thr < k);
			rev_ok = 1'b0;
			repeat (5) @(negedge sys_clk_i);
			chk("match_lamp", 4'h0, match_lamp);
			$display("test match done");
		end
	endtask

	task end_sim;
		begin
			$display("checks %0d mismatches %0d", tests_run, n_mismatch);
			if (n_mismatch == 0 && tests_run > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask

	initial begin
		#500000;
		n_mismatch = n_mismatch + 1;
		$display("mismatch watchdog expected done seen hang");
		end_sim;
	end

	initial begin
		for (i = 0; i < 4; i = i + 1)
			btn[i] = 4'h0;
		port_lev = 32'h0;
		stbd_lev = 32'h0;
		port_rev = 4'h0;
		stbd_rev = 4'h0;
		rev_ok = 1'b1;
		main_per = 0;
		aux_per = 0;
		n_mismatch = 0;
		tests_run = 0;
		rstn_i = 1'b0;
		repeat (6) @(negedge sys_clk_i);
		rstn_i = 1'b1;
		repeat (2) @(negedge sys_clk_i);
		t_power;
		t_lock;
		t_warm;
		t_match;
		end_sim;
	end
endmodule // tb_helm_station_mode_control

// ---- rtl/button_debounce.v ----
/*
 one debounced button: emits a single-cycle pulse per settled press.
 assumes the raw input is already synchronous to sys_clk_i.
*/
`timescale 1ns/1ps
module button_debounce #(
	parameter integer STABLE_CYCLES = 1000000,
	parameter integer CNT_W         = 24
) (
	// clock and reset
	input  wire sys_clk_i,
	input  wire rstn_i,
	// button
	input  wire raw_i,
	output reg  press_o
);
	reg             state_r;
	reg [CNT_W-1:0] cnt_r;

	// the level must hold for the full count before it is believed, so contact chatter never toggles twice
	always @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_r <= 1'b0;
			cnt_r   <= {CNT_W{1'b0}};
			press_o <= 1'b0;
		end else begin
			press_o <= 1'b0;
			if (raw_i == state_r) begin
				cnt_r <= {CNT_W{1'b0}};
			end else if (cnt_r == STABLE_CYCLES[CNT_W-1:0] - 1'b1) begin
				cnt_r   <= {CNT_W{1'b0}};
				state_r <= raw_i;
				press_o <= raw_i;
			end else begin
				cnt_r <= cnt_r + 1'b1;
			end
		end
	end
endmodule // button_debounce

// ---- rtl/helm_defines.vh ----
/*
 helm station mode control: shared constants (timing counts, codes, reset values).
 assumes a 100 MHz system clock; included by bare name.
*/
`ifndef HELM_DEFINES_VH
`define HELM_DEFINES_VH

`define CLK_PERIOD_NS      10
`define DEBOUNCE_TIME_US   10000
`define DEBOUNCE_CYCLES    ((`DEBOUNCE_TIME_US * 1000) / `CLK_PERIOD_NS)
`define FLASH_TIME_MS      500
`define FLASH_CYCLES       ((`FLASH_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define MATCH_WINDOW_MS    1000
`define MATCH_WINDOW_CYC   ((`MATCH_WINDOW_MS * 1000000) / `CLK_PERIOD_NS)
`define MAIN_STATION       0
`define LEVER_WINDOW_PCT   10
`define DEAD_BAND_PULSES   1
`define TRIM_RESET         8'h80
`define CLUTCH_NEUTRAL     2'h0
`define CLUTCH_FWD         2'h1
`define CLUTCH_REV         2'h2

`endif

// ---- rtl/helm_station_mode_control.v ----
/*
 helm station mode control: station transfer, transfer lock, warm-up mode and
 twin-shaft speed matching for a multi-station engine control.
 assumes all inputs are synchronous to sys_clk_i, buttons are raw per-station
 levels, levers are unsigned 0..LEV_MAX with neutral band at or below NEUTRAL_MAX,
 and shaft pickups give one clean pulse per revolution.
*/
// Operation
// - pressed station gets control; its transfer lamp lights until another is chosen
// - all operating functions follow the selected station's head only
// - power-up selects main station 0 (MAIN_STATION) and engages the transfer lock
// - after power-up nothing runs until neutral levers and a transfer press
// - lock press at active station engages lock; others cannot select
// - another lock press releases lock and darkens its lamp
// - warm-up entered only by button press at neutral; lamp lights
// - in warm-up throttle follows handle, clutch held neutral
// - neutral safety output stays enabled during warm-up
// - warm-up left only by button press at neutral
// - speed matching toggles only when port and starboard within 10%
// - match button press, levers permitting, activates speed matching
// - compare shaft pulse rates and trim auxiliary throttle to match main
// - matching lamp flashes while correcting
// - matching lamp steady when speeds inside the dead band
// - in matching mode both gearboxes follow the main handle
// - speed matching disabled when software revisions disagree
// - brake and neutral safety contacts closed at clutch neutral only
`timescale 1ns/1ps
`include "helm_defines.vh"
module helm_station_mode_control #(
	parameter integer NUM_STATIONS  = 4,
	parameter integer LEV_W         = 8,
	parameter integer LEV_MAX       = 255,
	parameter integer NEUTRAL_MAX   = 12,
	parameter integer DEBOUNCE_CYC  = `DEBOUNCE_CYCLES,
	parameter integer FLASH_CYC     = `FLASH_CYCLES,
	parameter integer WINDOW_CYC    = `MATCH_WINDOW_CYC,
	parameter integer DEAD_BAND     = `DEAD_BAND_PULSES,
	parameter integer TRIM_STEP     = 1
) (
	// clock and reset
	input  wire                          sys_clk_i,
	input  wire                          rstn_i,
	// station buttons, one bit per station
	input  wire [NUM_STATIONS-1:0]       transfer_btn_i,
	input  wire [NUM_STATIONS-1:0]       lock_btn_i,
	input  wire [NUM_STATIONS-1:0]       warmup_btn_i,
	input  wire [NUM_STATIONS-1:0]       shaft_match_btn_i,
	// station levers, packed station-major; signed direction bit per handle
	input  wire [NUM_STATIONS*LEV_W-1:0] port_lever_i,
	input  wire [NUM_STATIONS*LEV_W-1:0] stbd_lever_i,
	input  wire [NUM_STATIONS-1:0]       port_dir_rev_i,
	input  wire [NUM_STATIONS-1:0]       stbd_dir_rev_i,
	// system inputs
	input  wire                          revision_match_i,
	input  wire                          main_pickup_i,
	input  wire                          aux_pickup_i,
	// station lamps
	output reg  [NUM_STATIONS-1:0]       transfer_lamp_o,
	output reg  [NUM_STATIONS-1:0]       lock_lamp_o,
	output reg  [NUM_STATIONS-1:0]       warmup_lamp_o,
	output reg  [NUM_STATIONS-1:0]       match_lamp_o,
	// engine outputs (port is main, starboard auxiliary)
	output reg  [LEV_W-1:0]              main_throttle_o,
	output reg  [LEV_W-1:0]              aux_throttle_o,
	output reg  [1:0]                    main_clutch_o,
	output reg  [1:0]                    aux_clutch_o,
	output reg                           brake_neutral_o,
	output reg                           operational_o,
	output reg  [NUM_STATIONS-1:0]       station_sel_o
);
	localparam integer SEL_W  = (NUM_STATIONS > 1) ? $clog2(NUM_STATIONS) : 1;
	localparam integer FCNT_W = $clog2(FLASH_CYC + 1);
	localparam integer WCNT_W = $clog2(WINDOW_CYC + 1);
	localparam integer PCNT_W = 16;
	localparam integer LEV_TOL  = (LEV_MAX * `LEVER_WINDOW_PCT) / 100;
	localparam integer MAIN_SEL = `MAIN_STATION;

	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_RUN  = 2'h1;
	localparam [1:0] ST_WARM = 2'h2;

	// debounced press pulses
	wire [NUM_STATIONS-1:0] xfer_p;
	wire [NUM_STATIONS-1:0] lock_p;
	wire [NUM_STATIONS-1:0] warm_p;
	wire [NUM_STATIONS-1:0] match_p;

	genvar g;
	generate
		for (g = 0; g < 4*NUM_STATIONS; g = g + 1) begin : g_deb
			wire raw_w;
			wire pls_w;
			assign raw_w = (g < NUM_STATIONS)     ? transfer_btn_i[g % NUM_STATIONS] :
			               (g < 2*NUM_STATIONS)   ? lock_btn_i[g % NUM_STATIONS] :
			               (g < 3*NUM_STATIONS)   ? warmup_btn_i[g % NUM_STATIONS] :
			                                        shaft_match_btn_i[g % NUM_STATIONS];
			button_debounce #(
				.STABLE_CYCLES (DEBOUNCE_CYC),
				.CNT_W         ($clog2(DEBOUNCE_CYC + 1))
			) u_deb (
				.sys_clk_i (sys_clk_i),
				.rstn_i    (rstn_i),
				.raw_i     (raw_w),
				.press_o   (pls_w)
			);
			if (g < NUM_STATIONS) begin : g_x
				assign xfer_p[g] = pls_w;
			end else if (g < 2*NUM_STATIONS) begin : g_l
				assign lock_p[g-NUM_STATIONS] = pls_w;
			end else if (g < 3*NUM_STATIONS) begin : g_w
				assign warm_p[g-2*NUM_STATIONS] = pls_w;
			end else begin : g_m
				assign match_p[g-3*NUM_STATIONS] = pls_w;
			end
		end
	endgenerate

	// lowest pressing station wins a simultaneous transfer
	function [SEL_W:0] first_set;
		input [NUM_STATIONS-1:0] v;
		integer k;
		begin
			first_set = {(SEL_W+1){1'b0}};
			for (k = NUM_STATIONS-1; k >= 0; k = k - 1) begin
				if (v[k]) begin
					first_set = {1'b1, k[SEL_W-1:0]};
				end
			end
		end
	endfunction

	function [LEV_W-1:0] lever_of;
		input [NUM_STATIONS*LEV_W-1:0] bus;
		input [SEL_W-1:0]              idx;
		begin
			lever_of = bus[idx*LEV_W +: LEV_W];
		end
	endfunction

	reg [1:0]       state_r;
	reg [1:0]       state_nxt;
	reg [SEL_W-1:0] sel_r;
	reg [SEL_W-1:0] sel_nxt;
	reg             lock_r;
	reg             lock_nxt;
	reg             match_r;
	reg             match_nxt;

	// selected head's handles only; other heads' handles are never looked at
	wire [LEV_W-1:0] port_lev = lever_of(port_lever_i, sel_r);
	wire [LEV_W-1:0] stbd_lev = lever_of(stbd_lever_i, sel_r);
	wire             port_rev = port_dir_rev_i[sel_r];
	wire             stbd_rev = stbd_dir_rev_i[sel_r];
	wire             at_neutral = (port_lev <= NEUTRAL_MAX[LEV_W-1:0]) && (stbd_lev <= NEUTRAL_MAX[LEV_W-1:0]);
	wire [LEV_W:0]   lev_diff = (port_lev > stbd_lev) ? {1'b0, port_lev - stbd_lev} : {1'b0, stbd_lev - port_lev};
	wire             levers_close = (lev_diff <= LEV_TOL[LEV_W:0]) && (port_rev == stbd_rev);
	wire [SEL_W:0]   xfer_req = first_set(xfer_p);
	wire             own_xfer = xfer_p[sel_r];
	wire             own_lock = lock_p[sel_r];
	wire             own_warm = warm_p[sel_r];
	wire             own_match = match_p[sel_r];

	// station, lock and mode sequencing
	always @* begin
		state_nxt = state_r;
		sel_nxt   = sel_r;
		lock_nxt  = lock_r;
		match_nxt = match_r;
		case (state_r)
			ST_IDLE: begin
				// the power-up lock still holds, so only the main head can take control
				if (own_xfer && at_neutral) begin
					state_nxt = ST_RUN;
				end
			end
			ST_RUN: begin
				if (xfer_req[SEL_W] && !lock_r && (xfer_req[SEL_W-1:0] != sel_r)) begin
					sel_nxt = xfer_req[SEL_W-1:0];
				end else if (own_lock) begin
					lock_nxt = ~lock_r;
				end else if (own_warm && at_neutral) begin
					state_nxt = ST_WARM;
					match_nxt = 1'b0;
				end else if (own_match && levers_close) begin
					match_nxt = ~match_r & revision_match_i;
				end
				if (!revision_match_i) begin
					match_nxt = 1'b0;
				end
			end
			ST_WARM: begin
				if (own_lock) begin
					lock_nxt = ~lock_r;
				end else if (own_warm && at_neutral) begin
					state_nxt = ST_RUN;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_r <= ST_IDLE;
			sel_r   <= MAIN_SEL[SEL_W-1:0];
			lock_r  <= 1'b1;
			match_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			sel_r   <= sel_nxt;
			lock_r  <= lock_nxt;
			match_r <= match_nxt;
		end
	end

	// shaft pulse rate comparison over a fixed window
	reg              main_d_r;
	reg              aux_d_r;
	reg [WCNT_W-1:0] win_r;
	reg [PCNT_W-1:0] main_cnt_r;
	reg [PCNT_W-1:0] aux_cnt_r;
	reg [LEV_W-1:0]  trim_r;
	reg              in_band_r;
	wire             main_edge = main_pickup_i & ~main_d_r;
	wire             aux_edge  = aux_pickup_i & ~aux_d_r;
	wire             win_end   = (win_r == WINDOW_CYC[WCNT_W-1:0] - 1'b1);
	wire [PCNT_W:0]  rate_diff = {1'b0, main_cnt_r} - {1'b0, aux_cnt_r};
	wire             aux_slow  = !rate_diff[PCNT_W] && (rate_diff[PCNT_W-1:0] > DEAD_BAND[PCNT_W-1:0]);
	wire             aux_fast  = rate_diff[PCNT_W] && ((aux_cnt_r - main_cnt_r) > DEAD_BAND[PCNT_W-1:0]);

	always @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			main_d_r   <= 1'b0;
			aux_d_r    <= 1'b0;
			win_r      <= {WCNT_W{1'b0}};
			main_cnt_r <= {PCNT_W{1'b0}};
			aux_cnt_r  <= {PCNT_W{1'b0}};
			trim_r     <= `TRIM_RESET;
			in_band_r  <= 1'b0;
		end else begin
			main_d_r <= main_pickup_i;
			aux_d_r  <= aux_pickup_i;
			if (!match_r) begin
				win_r      <= {WCNT_W{1'b0}};
				main_cnt_r <= {PCNT_W{1'b0}};
				aux_cnt_r  <= {PCNT_W{1'b0}};
				trim_r     <= `TRIM_RESET;
				in_band_r  <= 1'b0;
			end else if (win_end) begin
				win_r      <= {WCNT_W{1'b0}};
				main_cnt_r <= {PCNT_W{1'b0}};
				aux_cnt_r  <= {PCNT_W{1'b0}};
				in_band_r  <= !aux_slow && !aux_fast;
				// trim saturates rather than wraps, so a stuck pickup cannot slam the throttle
				if (aux_slow && (trim_r <= {LEV_W{1'b1}} - TRIM_STEP[LEV_W-1:0])) begin
					trim_r <= trim_r + TRIM_STEP[LEV_W-1:0];
				end else if (aux_fast && (trim_r >= TRIM_STEP[LEV_W-1:0])) begin
					trim_r <= trim_r - TRIM_STEP[LEV_W-1:0];
				end
			end else begin
				win_r <= win_r + 1'b1;
				if (main_edge && (main_cnt_r != {PCNT_W{1'b1}})) begin
					main_cnt_r <= main_cnt_r + 1'b1;
				end
				if (aux_edge && (aux_cnt_r != {PCNT_W{1'b1}})) begin
					aux_cnt_r <= aux_cnt_r + 1'b1;
				end
			end
		end
	end

	// lamp flash timebase
	reg [FCNT_W-1:0] flash_cnt_r;
	reg              flash_r;
	always @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			flash_cnt_r <= {FCNT_W{1'b0}};
			flash_r     <= 1'b0;
		end else if (flash_cnt_r == FLASH_CYC[FCNT_W-1:0] - 1'b1) begin
			flash_cnt_r <= {FCNT_W{1'b0}};
			flash_r     <= ~flash_r;
		end else begin
			flash_cnt_r <= flash_cnt_r + 1'b1;
		end
	end

	// engine commands and lamps
	reg [LEV_W:0] aux_sum;
	reg [LEV_W-1:0] aux_cmd;
	reg [1:0] main_cl;
	reg [1:0] aux_cl;
	always @* begin
		aux_sum = {1'b0, port_lev} + {1'b0, trim_r} - {1'b0, `TRIM_RESET};
		if (trim_r >= `TRIM_RESET) begin
			aux_cmd = aux_sum[LEV_W] ? {LEV_W{1'b1}} : aux_sum[LEV_W-1:0];
		end else begin
			aux_cmd = (port_lev < (`TRIM_RESET - trim_r)) ? {LEV_W{1'b0}} : aux_sum[LEV_W-1:0];
		end
		main_cl = at_neutral ? `CLUTCH_NEUTRAL : (port_rev ? `CLUTCH_REV : `CLUTCH_FWD);
		aux_cl  = (stbd_lev <= NEUTRAL_MAX[LEV_W-1:0]) ? `CLUTCH_NEUTRAL : (stbd_rev ? `CLUTCH_REV : `CLUTCH_FWD);
		if (match_r) begin
			aux_cl = (port_lev <= NEUTRAL_MAX[LEV_W-1:0]) ? `CLUTCH_NEUTRAL :
			         (port_rev ? `CLUTCH_REV : `CLUTCH_FWD);
		end
		if (port_lev <= NEUTRAL_MAX[LEV_W-1:0]) begin
			main_cl = `CLUTCH_NEUTRAL;
		end
	end

	always @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			main_throttle_o <= {LEV_W{1'b0}};
			aux_throttle_o  <= {LEV_W{1'b0}};
			main_clutch_o   <= `CLUTCH_NEUTRAL;
			aux_clutch_o    <= `CLUTCH_NEUTRAL;
			brake_neutral_o <= 1'b1;
			operational_o   <= 1'b0;
			station_sel_o   <= {NUM_STATIONS{1'b0}};
			transfer_lamp_o <= {NUM_STATIONS{1'b0}};
			lock_lamp_o     <= {NUM_STATIONS{1'b0}};
			warmup_lamp_o   <= {NUM_STATIONS{1'b0}};
			match_lamp_o    <= {NUM_STATIONS{1'b0}};
		end else begin
			operational_o   <= (state_r != ST_IDLE);
			station_sel_o   <= {{(NUM_STATIONS-1){1'b0}}, 1'b1} << sel_r;
			transfer_lamp_o <= (state_r != ST_IDLE) ? ({{(NUM_STATIONS-1){1'b0}}, 1'b1} << sel_r)
			                                        : {NUM_STATIONS{1'b0}};
			lock_lamp_o     <= lock_r ? ({{(NUM_STATIONS-1){1'b0}}, 1'b1} << sel_r)
			                          : {NUM_STATIONS{1'b0}};
			warmup_lamp_o   <= (state_r == ST_WARM) ? ({{(NUM_STATIONS-1){1'b0}}, 1'b1} << sel_r)
			                                        : {NUM_STATIONS{1'b0}};
			match_lamp_o    <= (match_r && (in_band_r || flash_r)) ? ({{(NUM_STATIONS-1){1'b0}}, 1'b1} << sel_r)
			                                                       : {NUM_STATIONS{1'b0}};
			case (state_r)
				ST_RUN: begin
					main_throttle_o <= port_lev;
					aux_throttle_o  <= match_r ? aux_cmd : stbd_lev;
					main_clutch_o   <= main_cl;
					aux_clutch_o    <= aux_cl;
					brake_neutral_o <= (main_cl == `CLUTCH_NEUTRAL) && (aux_cl == `CLUTCH_NEUTRAL);
				end
				ST_WARM: begin
					main_throttle_o <= port_lev;
					aux_throttle_o  <= stbd_lev;
					main_clutch_o   <= `CLUTCH_NEUTRAL;
					aux_clutch_o    <= `CLUTCH_NEUTRAL;
					brake_neutral_o <= 1'b1;
				end
				default: begin
					main_throttle_o <= {LEV_W{1'b0}};
					aux_throttle_o  <= {LEV_W{1'b0}};
					main_clutch_o   <= `CLUTCH_NEUTRAL;
					aux_clutch_o    <= `CLUTCH_NEUTRAL;
					brake_neutral_o <= 1'b1;
				end
			endcase
		end
	end
endmodule // helm_station_mode_control
